// file: core/pct_defines.vh
`ifndef PCT_DEFINES_VH
`define PCT_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PCT_OFF_CTRL 8'h00
`define PCT_OFF_STAT 8'h04
`define PCT_OFF_MASK 8'h08
`define PCT_OFF_DMAEN 8'h0C
`define PCT_OFF_PRESC 8'h10
`define PCT_OFF_RELOAD 8'h14
`define PCT_OFF_COUNT 8'h18
`define PCT_OFF_DEAD 8'h1C
`define PCT_OFF_CHMODE 8'h20
`define PCT_OFF_CMP0 8'h40
`define PCT_OFF_CMP1 8'h44
`define PCT_OFF_CMP2 8'h48
`define PCT_OFF_CMP3 8'h4C

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define PCT_CTRL_EN 0
`define PCT_CTRL_MODE 2:1
`define PCT_CTRL_ONEPULSE 3
`define PCT_CTRL_DBGFRZ 4
`define PCT_CTRL_SLAVE 6:5
`define PCT_CTRL_TSEL 8:7
`define PCT_CTRL_OUTEN 9
`define PCT_CTRL_W 10

// ------------------------------------------------------------
// status layout and encodings
// ------------------------------------------------------------
`define PCT_ST_UPD 0
`define PCT_ST_W 5
`define PCT_ST_DIR 5
`define PCT_MODE_UP 2'h0
`define PCT_MODE_DOWN 2'h1
`define PCT_MODE_CENTRE 2'h2
`define PCT_MODE_ENC 2'h3
`define PCT_SLV_OFF 2'h0
`define PCT_SLV_START 2'h1
`define PCT_SLV_GATE 2'h2
`define PCT_SLV_EXTCLK 2'h3
`define PCT_CH_OFF 2'h0
`define PCT_CH_CAPTURE 2'h1
`define PCT_CH_COMPARE 2'h2
`define PCT_CH_PWM 2'h3
`define PCT_CHM_FALL 2

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define PCT_RST_CTRL 10'h000
`define PCT_RST_RELOAD 32'h0000FFFF
`define PCT_RST_DEAD 8'h00
`define PCT_DEAD_W 8

`endif

// file: core/pct_deadtime.v
`timescale 1ns/1ps
`include "pct_defines.vh"

module pct_deadtime (
   input wire clk_sys, // timer clock
   input wire rst_b, // async reset, low
   input wire enable, // pair may drive
   input wire level, // wanted phase level
   input wire [`PCT_DEAD_W-1:0] dead, // gap in cycles
   output reg outHi, // primary switch
   output reg outLo // complementary switch
);

   // ----------------------------------------------------------
   // state machine
   // ----------------------------------------------------------
   localparam [3:0] ST_OFF = 4'h1;
   localparam [3:0] ST_HI = 4'h2;
   localparam [3:0] ST_LO = 4'h4;
   localparam [3:0] ST_GAP = 4'h8;

   reg [3:0] state;
   reg [`PCT_DEAD_W-1:0] gapCnt;

   // both off during the gap, new side after the count
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_OFF;
         gapCnt <= {`PCT_DEAD_W{1'b0}};
         outHi <= 1'b0;
         outLo <= 1'b0;
      end else if (!enable) begin
         state <= ST_OFF;
         gapCnt <= {`PCT_DEAD_W{1'b0}};
         outHi <= 1'b0;
         outLo <= 1'b0;
      end else begin
         case (state)
            ST_HI, ST_LO, ST_OFF: begin
               if ((state == ST_HI) != level || state == ST_OFF) begin
                  outHi <= 1'b0;
                  outLo <= 1'b0;
                  gapCnt <= {`PCT_DEAD_W{1'b0}};
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (gapCnt >= dead) begin
                  outHi <= level;
                  outLo <= ~level;
                  state <= level ? ST_HI : ST_LO;
               end else begin
                  gapCnt <= gapCnt + 1'b1;
               end
            end
            default: begin
               state <= ST_OFF;
               outHi <= 1'b0;
               outLo <= 1'b0;
            end
         endcase
      end
   end

endmodule // pct_deadtime

// file: core/pct_timer.v
`timescale 1ns/1ps
`include "pct_defines.vh"

module pct_timer #(
   parameter CNT_W = 16, // counter width
   parameter PSC_W = 16, // prescaler width
   parameter NUM_CH = 4, // channels 0..3
   parameter NUM_PAIR = 3, // complementary pairs 0..2
   parameter UPDOWN_EN = 1, // down/centre allowed
   parameter ENC_EN = 0 // encoder allowed
) (
   input wire clk_sys, // timer clock
   input wire rst_b, // async reset, low
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output reg [31:0] avs_readdata, // read data
   output wire avs_waitrequest, // stall
   input wire [3:0] capIn, // capture pins
   input wire encA, // encoder phase A pin
   input wire encB, // encoder phase B pin
   input wire [3:0] trigIn, // sibling triggers
   input wire dbgHalt, // debug halt level
   output wire [3:0] chOut, // channel outputs
   output wire [2:0] chOutN, // complementary outputs
   output reg trgOut, // update pulse to siblings
   output reg dacTrig, // converter trigger pulse
   output reg [4:0] dmaReq, // dma request pulses
   output reg irq // interrupt level
);

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function [31:0] laneMerge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer i;
      begin
         laneMerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               laneMerge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   function [31:0] widen;
      input [31:0] v;
      begin
         widen = v;
      end
   endfunction

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   reg [`PCT_CTRL_W-1:0] ctrl;
   reg [`PCT_ST_W-1:0] stat;
   reg [`PCT_ST_W-1:0] mask;
   reg [`PCT_ST_W-1:0] dmaEn;
   reg [PSC_W-1:0] presc;
   reg [CNT_W-1:0] reload;
   reg [CNT_W-1:0] cnt;
   reg [`PCT_DEAD_W-1:0] dead;
   reg [15:0] chMode;
   reg [CNT_W-1:0] cmp [0:3];
   reg ack;
   reg cntDown;
   reg [PSC_W-1:0] pscCnt;
   localparam [31:0] RST_RELOAD = `PCT_RST_RELOAD;

   wire busReq = avs_read | avs_write;
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire wrDo = avs_write & ack;
   wire [7:0] wAddr = {avs_address[7:2], 2'b00};
   wire [31:0] wData = avs_writedata & wmask;

   // one wait cycle, then the access completes
   assign avs_waitrequest = busReq & ~ack;

   // addressed register, zero padded, for reads and lane merges
   reg [31:0] rdMux;

   always @* begin
      case (wAddr)
         `PCT_OFF_CTRL: rdMux = widen(ctrl);
         `PCT_OFF_STAT: rdMux = widen({cntDown, stat});
         `PCT_OFF_MASK: rdMux = widen(mask);
         `PCT_OFF_DMAEN: rdMux = widen(dmaEn);
         `PCT_OFF_PRESC: rdMux = widen(presc);
         `PCT_OFF_RELOAD: rdMux = widen(reload);
         `PCT_OFF_COUNT: rdMux = widen(cnt);
         `PCT_OFF_DEAD: rdMux = widen(dead);
         `PCT_OFF_CHMODE: rdMux = widen(chMode);
         `PCT_OFF_CMP0: rdMux = widen(cmp[0]);
         `PCT_OFF_CMP1: rdMux = widen(cmp[1]);
         `PCT_OFF_CMP2: rdMux = widen(cmp[2]);
         `PCT_OFF_CMP3: rdMux = widen(cmp[3]);
         default: rdMux = 32'h00000000;
      endcase
   end

   wire [31:0] merged = laneMerge(rdMux, avs_writedata, avs_byteenable);

   // ----------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------
   reg [5:0] pinS1;
   reg [5:0] pinS2;
   reg [5:0] pinPrev;
   reg trgPrev;
   wire trgLvl;

   // capture and encoder pins pass two flops
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinS1 <= 6'h00;
         pinS2 <= 6'h00;
         pinPrev <= 6'h00;
         trgPrev <= 1'b0;
      end else begin
         pinS1 <= {encB, encA, capIn};
         pinS2 <= pinS1;
         pinPrev <= pinS2;
         trgPrev <= trgLvl;
      end
   end

   // ----------------------------------------------------------
   // run control and trigger link
   // ----------------------------------------------------------
   wire [1:0] slave = ctrl[`PCT_CTRL_SLAVE];
   assign trgLvl = trigIn[ctrl[`PCT_CTRL_TSEL]];
   wire trgRise = trgLvl & ~trgPrev;
   wire frozen = ctrl[`PCT_CTRL_DBGFRZ] & dbgHalt;
   wire gateOk = (slave != `PCT_SLV_GATE) | trgLvl;
   wire run = ctrl[`PCT_CTRL_EN] & ~frozen & gateOk;
   wire [1:0] modeReq = ctrl[`PCT_CTRL_MODE];
   wire [1:0] mode = (modeReq == `PCT_MODE_ENC) ?
      (ENC_EN != 0 ? `PCT_MODE_ENC : `PCT_MODE_UP) :
      (UPDOWN_EN != 0 ? modeReq : `PCT_MODE_UP);
   wire encMode = (mode == `PCT_MODE_ENC);

   // ----------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------
   // external clock from sibling event
   wire srcEv = (slave == `PCT_SLV_EXTCLK) ? trgRise : 1'b1;
   wire pscDone = (pscCnt >= presc);
   wire tick = run & srcEv & pscDone & ~encMode;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pscCnt <= {PSC_W{1'b0}};
      end else if (run & srcEv) begin
         pscCnt <= pscDone ? {PSC_W{1'b0}} : pscCnt + 1'b1;
      end
   end

   // ----------------------------------------------------------
   // encoder decode
   // ----------------------------------------------------------
   wire encAs = pinS2[4];
   wire encBs = pinS2[5];
   wire encStep = run & encMode &
      ((encAs ^ pinPrev[4]) | (encBs ^ pinPrev[5]));
   wire encUp = pinPrev[4] ^ encBs;

   // ----------------------------------------------------------
   // counter next state
   // ----------------------------------------------------------
   reg [CNT_W-1:0] next_cnt;
   reg next_down;
   reg updEv;

   always @* begin
      next_cnt = cnt;
      next_down = cntDown;
      updEv = 1'b0;
      if (encStep) begin
         if (encUp) begin
            next_cnt = (cnt >= reload) ? {CNT_W{1'b0}} : cnt + 1'b1;
            updEv = (cnt >= reload);
         end else begin
            next_cnt = (cnt == {CNT_W{1'b0}}) ? reload : cnt - 1'b1;
            updEv = (cnt == {CNT_W{1'b0}});
         end
         next_down = ~encUp;
      end else if (tick) begin
         case (mode)
            `PCT_MODE_DOWN: begin
               next_down = 1'b1;
               next_cnt = (cnt == {CNT_W{1'b0}}) ? reload : cnt - 1'b1;
               updEv = (cnt == {CNT_W{1'b0}});
            end
            `PCT_MODE_CENTRE: begin
               if (!cntDown && cnt >= reload) begin
                  next_down = 1'b1;
                  next_cnt = cnt - 1'b1;
                  updEv = 1'b1;
               end else if (cntDown && cnt == {CNT_W{1'b0}}) begin
                  next_down = 1'b0;
                  next_cnt = cnt + 1'b1;
                  updEv = 1'b1;
               end else begin
                  next_cnt = cntDown ? cnt - 1'b1 : cnt + 1'b1;
               end
            end
            default: begin
               next_down = 1'b0;
               next_cnt = (cnt >= reload) ? {CNT_W{1'b0}} : cnt + 1'b1;
               updEv = (cnt >= reload);
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // channel events
   // ----------------------------------------------------------
   reg [3:0] chEv;
   reg [3:0] pwmLvl;
   integer c;

   always @* begin
      chEv = 4'h0;
      pwmLvl = 4'h0;
      for (c = 0; c < 4; c = c + 1) begin
         if (c < NUM_CH) begin
            case (chMode[c*4 +: 2])
               `PCT_CH_CAPTURE: begin
                  chEv[c] = chMode[c*4 + `PCT_CHM_FALL] ?
                     (~pinS2[c] & pinPrev[c]) : (pinS2[c] & ~pinPrev[c]);
               end
               `PCT_CH_COMPARE, `PCT_CH_PWM: begin
                  chEv[c] = (tick | encStep) & (cnt == cmp[c]);
               end
               default: begin
                  chEv[c] = 1'b0;
               end
            endcase
            // zero gives off, above reload on
            pwmLvl[c] = (cnt < cmp[c]);
         end
      end
   end

   // ----------------------------------------------------------
   // register writes, counter, captures
   // ----------------------------------------------------------
   wire [`PCT_ST_W-1:0] evSet = {chEv, updEv};
   wire [`PCT_ST_W-1:0] stClr = (wrDo && wAddr == `PCT_OFF_STAT) ?
      wData[`PCT_ST_W-1:0] : {`PCT_ST_W{1'b0}};
   integer k;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `PCT_RST_CTRL;
         stat <= {`PCT_ST_W{1'b0}};
         mask <= {`PCT_ST_W{1'b0}};
         dmaEn <= {`PCT_ST_W{1'b0}};
         presc <= {PSC_W{1'b0}};
         reload <= RST_RELOAD[CNT_W-1:0];
         cnt <= {CNT_W{1'b0}};
         cntDown <= 1'b0;
         dead <= `PCT_RST_DEAD;
         chMode <= 16'h0000;
         for (k = 0; k < 4; k = k + 1) begin
            cmp[k] <= {CNT_W{1'b0}};
         end
      end else begin
         // set wins over write-one clear
         stat <= (stat & ~stClr) | evSet;
         cnt <= next_cnt;
         cntDown <= next_down;
         if (slave == `PCT_SLV_START && trgRise) begin
            ctrl[`PCT_CTRL_EN] <= 1'b1;
         end
         if (updEv && ctrl[`PCT_CTRL_ONEPULSE]) begin
            ctrl[`PCT_CTRL_EN] <= 1'b0;
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (chEv[k] && chMode[k*4 +: 2] == `PCT_CH_CAPTURE) begin
               cmp[k] <= cnt;
            end
         end
         if (wrDo) begin
            case (wAddr)
               `PCT_OFF_CTRL: ctrl <= merged[`PCT_CTRL_W-1:0];
               `PCT_OFF_MASK: mask <= merged[`PCT_ST_W-1:0];
               `PCT_OFF_DMAEN: dmaEn <= merged[`PCT_ST_W-1:0];
               `PCT_OFF_PRESC: presc <= merged[PSC_W-1:0];
               `PCT_OFF_RELOAD: reload <= merged[CNT_W-1:0];
               `PCT_OFF_COUNT: cnt <= merged[CNT_W-1:0];
               `PCT_OFF_DEAD: dead <= merged[`PCT_DEAD_W-1:0];
               `PCT_OFF_CHMODE: chMode <= merged[15:0];
               `PCT_OFF_CMP0: cmp[0] <= merged[CNT_W-1:0];
               `PCT_OFF_CMP1: cmp[1] <= merged[CNT_W-1:0];
               `PCT_OFF_CMP2: cmp[2] <= merged[CNT_W-1:0];
               `PCT_OFF_CMP3: cmp[3] <= merged[CNT_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // bus handshake and read mux
   // ----------------------------------------------------------
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         ack <= busReq & ~ack;
         if (avs_read && !ack) begin
            avs_readdata <= rdMux;
         end
      end
   end

   // ----------------------------------------------------------
   // event outputs, dma, interrupt
   // ----------------------------------------------------------
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trgOut <= 1'b0;
         dacTrig <= 1'b0;
         dmaReq <= 5'h00;
         irq <= 1'b0;
      end else begin
         trgOut <= updEv;
         dacTrig <= updEv;
         dmaReq <= evSet & dmaEn;
         irq <= |(stat & mask);
      end
   end

   // ----------------------------------------------------------
   // channel output levels
   // ----------------------------------------------------------
   reg [3:0] chLvl;
   reg [3:0] cmpTog;
   integer m;
   wire outOk = ctrl[`PCT_CTRL_OUTEN] & ~frozen;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         chLvl <= 4'h0;
         cmpTog <= 4'h0;
      end else begin
         for (m = 0; m < 4; m = m + 1) begin
            if (chEv[m] && chMode[m*4 +: 2] == `PCT_CH_COMPARE) begin
               cmpTog[m] <= ~cmpTog[m];
            end
            if (!outOk || m >= NUM_CH) begin
               chLvl[m] <= 1'b0;
            end else if (chMode[m*4 +: 2] == `PCT_CH_PWM) begin
               chLvl[m] <= pwmLvl[m];
            end else if (chMode[m*4 +: 2] == `PCT_CH_COMPARE) begin
               chLvl[m] <= cmpTog[m];
            end else begin
               chLvl[m] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // complementary pairs
   // ----------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gPair
         if (g < NUM_PAIR && g < NUM_CH) begin : gOn
            wire hi;
            wire lo;
            pct_deadtime uDead (
               .clk_sys(clk_sys),
               .rst_b(rst_b),
               .enable(outOk),
               .level(chLvl[g]),
               .dead(dead),
               .outHi(hi),
               .outLo(lo)
            );
            assign chOut[g] = hi;
            assign chOutN[g] = lo;
         end else begin : gOff
            assign chOut[g] = chLvl[g];
            assign chOutN[g] = 1'b0;
         end
      end
   endgenerate
   assign chOut[3] = chLvl[3];

endmodule // pct_timer

// file: test/pct_checker.sv
`timescale 1ns/1ps
`include "pct_defines.vh"

module pct_checker (
   input wire clk_sys, // timer clock
   input wire rst_b, // reset, low
   input wire [7:0] avs_address, // byte address
   input wire avs_read, // read
   input wire avs_write, // write
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // lanes
   input wire avs_waitrequest, // stall
   input wire dbgHalt, // debug halt
   input wire [3:0] chOut, // channel outs
   input wire [2:0] chOutN, // complements
   input wire trgOut, // update pulse
   input wire dacTrig, // converter pulse
   input wire [4:0] dmaReq, // dma pulses
   input wire irq // interrupt
);
   reg frz;
   reg maskZero;
   // shadow of freeze bit and mask
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         frz <= 1'b0;
         maskZero <= 1'b1;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
         if (avs_address[7:2] == 6'h00) frz <= avs_writedata[`PCT_CTRL_DBGFRZ];
         if (avs_address[7:2] == 6'h02) maskZero <= (avs_writedata[4:0] == 5'h00);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_wait; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus wait not one cycle");
   property p_link; trgOut |-> dacTrig; endproperty
   a_link: assert property (p_link) else $error("converter trigger missing");
   property p_dma; dmaReq[0] |-> trgOut; endproperty
   a_dma: assert property (p_dma) else $error("update dma without update");
   property p_both; (chOut[2:0] & chOutN) == 3'h0; endproperty
   a_both: assert property (p_both) else $error("pair both on");
   property p_gapn; $rose(chOutN[0]) |-> !$past(chOut[0]); endproperty
   a_gapn: assert property (p_gapn) else $error("no gap before complement");
   property p_gapp; $rose(chOut[0]) |-> !$past(chOutN[0]); endproperty
   a_gapp: assert property (p_gapp) else $error("no gap before primary");
   property p_dbg; dbgHalt && frz |=> chOut == 4'h0 && chOutN == 3'h0; endproperty
   a_dbg: assert property (p_dbg) else $error("outputs on in debug halt");
   property p_irq; maskZero && $past(maskZero) && $past(maskZero, 2) |-> !irq; endproperty
   a_irq: assert property (p_irq) else $error("irq with mask clear");
   c_upd: cover property (trgOut);
   c_dead: cover property ($rose(chOutN[0]));
   c_irq: cover property (irq);
endmodule // pct_checker

bind pct_timer pct_checker chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .dbgHalt(dbgHalt),
   .chOut(chOut), .chOutN(chOutN), .trgOut(trgOut), .dacTrig(dacTrig), .dmaReq(dmaReq),
   .irq(irq));

// file: test/pct_partner.sv
`timescale 1ns/1ps

module pct_partner (
   input wire clk_sys, // timer clock
   input wire rst_b, // reset, low
   input wire [3:0] capLvl, // wanted capture levels
   input wire [3:0] trigLvl, // wanted trigger levels
   input wire [3:0] chOut, // switch gates high
   input wire [2:0] chOutN, // switch gates low
   output reg [3:0] capIn, // signal sources
   output reg [3:0] trigIn, // sibling triggers
   output reg [7:0] shoot // shoot-through cycles
);
   // sources and siblings change just after an edge
   // sibling trigger drive
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         capIn <= 4'h0;
         trigIn <= 4'h0;
         shoot <= 8'h00;
      end else begin
         capIn <= capLvl;
         trigIn <= trigLvl;
         if ((chOut[2:0] & chOutN) != 3'h0) shoot <= shoot + 8'h01;
      end
   end
endmodule // pct_partner

// file: test/pct_timer_tb.sv
`timescale 1ns/1ps
`include "pct_defines.vh"

module pct_timer_tb;
   reg clk_sys, rst_b, rdS, wrS, dbgHalt;
   reg [7:0] adr;
   reg [31:0] wdat, v, w;
   reg [3:0] be, capLvl, trigLvl;
   wire [31:0] rdat;
   wire wt, trgOut, dacTrig, irq;
   wire [3:0] capIn, trigIn, chOut;
   wire [2:0] chOutN;
   wire [4:0] dmaReq;
   wire [7:0] shoot;
   integer miscompares, n_tests, i, j, n, hi, gap;
   pct_timer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr), .avs_read(rdS),
      .avs_write(wrS), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wt), .capIn(capIn), .encA(1'b0), .encB(1'b0), .trigIn(trigIn),
      .dbgHalt(dbgHalt), .chOut(chOut), .chOutN(chOutN), .trgOut(trgOut), .dacTrig(dacTrig),
      .dmaReq(dmaReq), .irq(irq));
   pct_partner far_u (.clk_sys(clk_sys), .rst_b(rst_b), .capLvl(capLvl), .trigLvl(trigLvl),
      .chOut(chOut), .chOutN(chOutN), .capIn(capIn), .trigIn(trigIn), .shoot(shoot));
   // compare and report
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one bus transfer, read data into v
   task acc(input rw, input [7:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge clk_sys);
         adr <= a;
         wdat <= d;
         be <= 4'hF;
         rdS <= !rw;
         wrS <= rw;
         k = 0;
         do begin
            @(posedge clk_sys);
            k = k + 1;
         end while (wt !== 1'b0 && k < 50);
         if (k >= 50) begin
            miscompares = miscompares + 1;
            complete_run;
         end
         v = rdat;
         rdS <= 1'b0;
         wrS <= 1'b0;
      end
   endtask
   // cycles between update pulses
   task per(output integer c);
      begin
         c = 0;
         while (trgOut !== 1'b1 && c < 300) begin
            @(negedge clk_sys);
            c = c + 1;
         end
         c = 0;
         do begin
            @(negedge clk_sys);
            c = c + 1;
         end while (trgOut !== 1'b1 && c < 300);
      end
   endtask
   // primary high and both-low counts
   task cnt(input integer len, output integer h, output integer g);
      integer k;
      begin
         h = 0;
         g = 0;
         for (k = 0; k < len; k = k + 1) begin
            @(negedge clk_sys);
            if (chOut[0] === 1'b1) h = h + 1;
            if (chOut[0] === 1'b0 && chOutN[0] === 1'b0) g = g + 1;
         end
      end
   endtask
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // watchdog
   initial begin
      #100000;
      miscompares = miscompares + 1;
      complete_run;
   end
   // main sequence
   initial begin
      {rst_b, rdS, wrS, dbgHalt, adr, wdat, be, capLvl, trigLvl} = 0;
      miscompares = 0;
      n_tests = 0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      acc(0, `PCT_OFF_CTRL, 32'h0);
      chk(v, {22'h0, `PCT_RST_CTRL});
      acc(0, `PCT_OFF_RELOAD, 32'h0);
      chk(v, `PCT_RST_RELOAD);
      acc(1, 8'h3C, 32'hFFFFFFFF);
      acc(0, 8'h3C, 32'h0);
      chk(v, 32'h0);
      $display("test reset done");
      acc(1, `PCT_OFF_DMAEN, 32'h1);
      acc(1, `PCT_OFF_RELOAD, 32'h4);
      for (i = 0; i < 4; i = i + 1) begin
         acc(1, `PCT_OFF_PRESC, (i == 3) ? 32'h2 : 32'h0);
         acc(1, `PCT_OFF_CTRL, 32'h1 | (((i == 3) ? 0 : i) << 1));
         per(n);
         per(n);
         chk(n, (i == 2) ? 4 : (i == 3) ? 15 : 5);
         acc(0, `PCT_OFF_STAT, 32'h0);
         chk(v[`PCT_ST_DIR], (i == 1) ? 1 : 0);
      end
      $display("test periods done");
      acc(1, `PCT_OFF_CTRL, 32'h0);
      acc(1, `PCT_OFF_MASK, 32'h1);
      repeat (3) @(negedge clk_sys);
      chk(irq, 1);
      acc(1, `PCT_OFF_MASK, 32'h0);
      repeat (3) @(negedge clk_sys);
      chk(irq, 0);
      acc(1, `PCT_OFF_MASK, 32'h1);
      acc(1, `PCT_OFF_STAT, 32'h1);
      repeat (3) @(negedge clk_sys);
      chk(irq, 0);
      acc(0, `PCT_OFF_STAT, 32'h0);
      chk(v[`PCT_ST_UPD], 0);
      $display("test interrupt done");
      acc(1, `PCT_OFF_CHMODE, 32'h3);
      acc(1, `PCT_OFF_PRESC, 32'h0);
      acc(1, `PCT_OFF_RELOAD, 32'h13);
      acc(1, `PCT_OFF_DEAD, 32'h3);
      for (j = 0; j <= 20; j = j + 10) begin
         acc(1, `PCT_OFF_CMP0, j);
         acc(1, `PCT_OFF_CTRL, 32'h201);
         per(n);
         per(n);
         cnt(40, hi, gap);
         chk(hi, (j == 0) ? 0 : (j == 20) ? 40 : 12);
         chk(gap, (j == 10) ? 16 : 0);
      end
      chk(shoot, 8'h00);
      $display("test pwm done");
      acc(1, `PCT_OFF_CTRL, 32'h211);
      @(posedge clk_sys);
      dbgHalt <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(chOut, 4'h0);
      acc(0, `PCT_OFF_COUNT, 32'h0);
      w = v;
      acc(0, `PCT_OFF_COUNT, 32'h0);
      chk(v, w);
      dbgHalt <= 1'b0;
      $display("test debug done");
      acc(1, `PCT_OFF_CHMODE, 32'h13);
      acc(1, `PCT_OFF_STAT, 32'h1F);
      capLvl <= 4'h2;
      repeat (10) @(negedge clk_sys);
      acc(0, `PCT_OFF_STAT, 32'h0);
      chk(v[2], 1);
      $display("test capture done");
      acc(1, `PCT_OFF_CTRL, 32'h120);
      acc(0, `PCT_OFF_COUNT, 32'h0);
      w = v;
      trigLvl <= 4'h4;
      repeat (10) @(negedge clk_sys);
      acc(0, `PCT_OFF_COUNT, 32'h0);
      chk(v != w, 1);
      $display("test trigger done");
      acc(1, `PCT_OFF_CTRL, 32'h9);
      repeat (45) @(negedge clk_sys);
      acc(0, `PCT_OFF_CTRL, 32'h0);
      chk(v, 32'h8);
      $display("test one-pulse done");
      complete_run;
   end
endmodule // pct_timer_tb
